// *** pkg/cfd_defs.vh ***
// constants for the clock fanout and half-rate divider block
`ifndef CFD_DEFS_VH
`define CFD_DEFS_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define CFD_OFS_CTRL 8'h00
`define CFD_OFS_STATUS 8'h04
`define CFD_OFS_EDGES 8'h08

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CFD_CTRL_SEL_BIT 0
`define CFD_CTRL_FLOAT_BIT 1
`define CFD_CTRL_DIV_LSB 2

// ----------------------------------------
// status register fields
// ----------------------------------------
`define CFD_STAT_SRC_BIT 0
`define CFD_STAT_HALF_BIT 1
`define CFD_STAT_DRIVE_BIT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define CFD_RST_SEL 1'h0
`define CFD_RST_FLOAT 1'h1
`define CFD_RST_DIV 1'h0
`define CFD_RST_EDGES 16'h0000

// ----------------------------------------
// sizes and limits
// ----------------------------------------
`define CFD_OUT_COUNT 10
`define CFD_GROUP_COUNT 3
`define CFD_FMAX_MHZ 150
`define CFD_CLK_MHZ 250

`endif

// *** logic/cfd_divider.v ***
// half-rate divider with full-rate retiming stage
`timescale 1ns/1ps
`include "cfd_defs.vh"

module cfd_divider (
    // clock and reset
    input wire clk,
    input wire rst,
    // control
    input wire holdReset,
    // selected source level
    input wire srcLevel,
    // retimed clocks and rise pulse
    output reg fullRate_reg,
    output reg halfRate_reg,
    output reg risePulse_reg
);

    reg srcPrev_reg;
    wire riseSeen;

    assign riseSeen = srcLevel & ~srcPrev_reg;

    // ----------------------------------------
    // divider and retime flops
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            srcPrev_reg <= 1'h0;
            fullRate_reg <= 1'h0;
            halfRate_reg <= 1'h0;
            risePulse_reg <= 1'h0;
        end else if (holdReset) begin
            srcPrev_reg <= srcLevel;
            fullRate_reg <= 1'h0;
            halfRate_reg <= 1'h0;
            risePulse_reg <= 1'h0;
        end else begin
            srcPrev_reg <= srcLevel;
            fullRate_reg <= srcLevel;
            risePulse_reg <= riseSeen;
            if (riseSeen) begin
                halfRate_reg <= ~halfRate_reg;
            end
        end
    end

endmodule // cfd_divider

// *** logic/cfd_top.v ***
// top of the clock fanout block with its wishbone register slave
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "cfd_defs.vh"

module cfd_top #(
    parameter OUT_COUNT = `CFD_OUT_COUNT,
    parameter GROUP_COUNT = `CFD_GROUP_COUNT,
    parameter EDGE_WIDTH = 16
) (
    // clock and reset
    input wire clk,
    input wire rst,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // clock sources
    input wire clockInputZero,
    input wire clockInputOne,
    // clock outputs, level and drive enable
    output reg [OUT_COUNT-1:0] clkOut,
    output reg [OUT_COUNT-1:0] clkOutEn
);

    // ----------------------------------------
    // helper functions
    // ----------------------------------------
    // group that an output belongs to
    function integer groupOf;
        input integer idx;
        begin
            groupOf = (idx * GROUP_COUNT) / OUT_COUNT;
        end
    endfunction

    // address match on a word offset
    function hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    // ----------------------------------------
    // control and status state
    // ----------------------------------------
    reg inputClockSelect_reg;
    reg masterResetOutputFloat_reg;
    reg [GROUP_COUNT-1:0] divideSelect_reg;
    reg [EDGE_WIDTH-1:0] edgeCount_reg;
    reg [31:0] readData_next;
    reg [OUT_COUNT-1:0] clkOut_next;
    reg [OUT_COUNT-1:0] clkOutEn_next;

    wire busRequest;
    wire writeStrobe;
    wire srcLevel;
    wire fullRate;
    wire halfRate;
    wire risePulse;

    integer i;

    // ----------------------------------------
    // source selection
    // ----------------------------------------
    // select zero or one input
    assign srcLevel = inputClockSelect_reg ? clockInputOne : clockInputZero;

    // ----------------------------------------
    // divider and retime stage
    // ----------------------------------------
    // plain edge logic, no rate floor
    cfd_divider uDivider (
        .clk(clk),
        .rst(rst),
        .holdReset(masterResetOutputFloat_reg),
        .srcLevel(srcLevel),
        .fullRate_reg(fullRate),
        .halfRate_reg(halfRate),
        .risePulse_reg(risePulse)
    );

    // ----------------------------------------
    // output fanout
    // ----------------------------------------
    always @* begin
        clkOut_next = {OUT_COUNT{1'h0}};
        clkOutEn_next = {OUT_COUNT{1'h0}};
        for (i = 0; i < OUT_COUNT; i = i + 1) begin
            if (divideSelect_reg[groupOf(i)]) begin
                clkOut_next[i] = halfRate;
            end else begin
                clkOut_next[i] = fullRate;
            end
            clkOutEn_next[i] = ~masterResetOutputFloat_reg;
            if (masterResetOutputFloat_reg) begin
                clkOut_next[i] = 1'h0;
            end
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            clkOut <= {OUT_COUNT{1'h0}};
            clkOutEn <= {OUT_COUNT{1'h0}};
        end else begin
            clkOut <= clkOut_next;
            clkOutEn <= clkOutEn_next;
        end
    end

    // ----------------------------------------
    // rising edge counter
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            edgeCount_reg <= `CFD_RST_EDGES;
        end else if (risePulse) begin
            edgeCount_reg <= edgeCount_reg + {{(EDGE_WIDTH-1){1'h0}}, 1'h1};
        end
    end

    // ----------------------------------------
    // wishbone handshake
    // ----------------------------------------
    assign busRequest = wb_cyc_i & wb_stb_i;
    assign writeStrobe = busRequest & wb_we_i & wb_ack_o & wb_sel_i[0];

    always @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'h0;
        end else begin
            wb_ack_o <= busRequest & ~wb_ack_o;
        end
    end

    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            inputClockSelect_reg <= `CFD_RST_SEL;
            masterResetOutputFloat_reg <= `CFD_RST_FLOAT;
            divideSelect_reg <= {GROUP_COUNT{`CFD_RST_DIV}};
        end else if (writeStrobe && hit(wb_adr_i, `CFD_OFS_CTRL)) begin
            inputClockSelect_reg <= wb_dat_i[`CFD_CTRL_SEL_BIT];
            masterResetOutputFloat_reg <= wb_dat_i[`CFD_CTRL_FLOAT_BIT];
            divideSelect_reg <= wb_dat_i[`CFD_CTRL_DIV_LSB +: GROUP_COUNT];
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always @* begin
        readData_next = 32'h00000000;
        if (hit(wb_adr_i, `CFD_OFS_CTRL)) begin
            readData_next[`CFD_CTRL_SEL_BIT] = inputClockSelect_reg;
            readData_next[`CFD_CTRL_FLOAT_BIT] = masterResetOutputFloat_reg;
            readData_next[`CFD_CTRL_DIV_LSB +: GROUP_COUNT] = divideSelect_reg;
        end else if (hit(wb_adr_i, `CFD_OFS_STATUS)) begin
            readData_next[`CFD_STAT_SRC_BIT] = fullRate;
            readData_next[`CFD_STAT_HALF_BIT] = halfRate;
            readData_next[`CFD_STAT_DRIVE_BIT] = ~masterResetOutputFloat_reg;
        end else if (hit(wb_adr_i, `CFD_OFS_EDGES)) begin
            readData_next[EDGE_WIDTH-1:0] = edgeCount_reg;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h00000000;
        end else if (busRequest & ~wb_ack_o & ~wb_we_i) begin
            wb_dat_o <= readData_next;
        end
    end

endmodule // cfd_top

// *** tb/cfd_src.sv ***
// gated clock source model
`timescale 1ns/1ps
module cfd_src #(parameter HALF = 2) (
    // clock and gate
    input wire clk,
    input wire run,
    // source clock
    output reg level = 1'b0
);
    integer cnt = 1;
    always @(posedge clk) begin
        cnt <= (run && cnt < HALF) ? cnt + 1 : 1;
        level <= run && (cnt < HALF ? level : ~level);
    end
endmodule // cfd_src

// *** tb/cfd_checker.sv ***
// assertions for the clock fanout block
`timescale 1ns/1ps
module cfd_checker #(parameter OUT_COUNT = 10) (
    // clock, reset and bus
    input wire clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o,
    // clocks
    input wire clockInputZero,
    input wire clockInputOne,
    input wire [OUT_COUNT-1:0] clkOut,
    input wire [OUT_COUNT-1:0] clkOutEn
);
    reg [4:0] ctl_reg;
    reg [2:0] q_reg;
    wire wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == 6'h00;
    wire src = ctl_reg[0] ? clockInputOne : clockInputZero;
    wire calm = q_reg == 3'h7;
    wire on = calm && !ctl_reg[1];
    wire mix = on && ctl_reg[4] && !ctl_reg[2];
    always @(posedge clk) begin
        ctl_reg <= rst ? 5'h02 : wr ? wb_dat_i[4:0] : ctl_reg;
        q_reg <= (rst || wr) ? 3'h0 : calm ? q_reg : q_reg + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_full; on && !ctl_reg[2] |-> clkOut[0] == $past(src, 2); endproperty
    a_full: assert property (p_full) else $error("full rate");
    property p_group; on |-> clkOut[3:1] == {3{clkOut[0]}} && clkOut[6:5] == {2{clkOut[4]}} &&
        clkOut[9:8] == {2{clkOut[7]}}; endproperty
    a_group: assert property (p_group) else $error("group");
    property p_align; mix && $changed(clkOut[9]) |-> $rose(clkOut[0]); endproperty
    a_align: assert property (p_align) else $error("align");
    property p_float; calm && ctl_reg[1] |-> clkOutEn == 0 && clkOut == 0; endproperty
    a_float: assert property (p_float) else $error("float");
    property p_drive; on |-> &clkOutEn; endproperty
    a_drive: assert property (p_drive) else $error("drive");
    property p_still; (on && $stable(src)) [*3] |-> $stable(clkOut); endproperty
    a_still: assert property (p_still) else $error("static");
    property p_toggle; mix && $rose(clkOut[0]) |-> $changed(clkOut[9]); endproperty
    a_toggle: assert property (p_toggle) else $error("toggle");
endmodule // cfd_checker
bind cfd_top cfd_checker #(.OUT_COUNT(OUT_COUNT)) cfd_checker_inst (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .clockInputZero, .clockInputOne, .clkOut, .clkOutEn);

// *** tb/test_cfd_top.sv ***
// bench for the clock fanout block
`timescale 1ns/1ps
module test_cfd_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg run = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [7:0] wb_adr_i = 8'h00;
    reg [3:0] wb_sel_i = 4'hF;
    reg [31:0] wb_dat_i = 32'h0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, clockInputZero, clockInputOne;
    wire [9:0] clkOut, clkOutEn;
    integer num_errors = 0, n_compared = 0, i;
    reg [2:0] lvl = 3'h0;
    reg [31:0] edges = 32'h0;
    cfd_src #(.HALF(2)) cfd_src_inst (.clk, .run, .level(clockInputZero));
    cfd_src #(.HALF(3)) cfd_src_b_inst (.clk, .run, .level(clockInputOne));
    cfd_top cfd_top_inst (.clk, .rst, .wb_cyc_i, .wb_stb_i(wb_cyc_i), .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .clockInputZero, .clockInputOne, .clkOut, .clkOutEn);
    always #2 clk = ~clk;
    task check(input [31:0] a, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (a !== e) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %0t %h %h", $time, a, e);
            end
        end
    endtask
    task wb(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            wb_cyc_i <= 1'b1;
            wb_we_i <= w;
            wb_adr_i <= a;
            wb_dat_i <= d;
            @(posedge clk);
            while (wb_ack_o !== 1'b1) begin
                @(posedge clk);
            end
            check({31'h0, wb_ack_o}, 32'h1);
            wb_cyc_i <= 1'b0;
        end
    endtask
    task tReset;
        begin
            wb(1'b0, 8'h00, 32'h0);
            check(wb_dat_o, 32'h2);
            wb(1'b0, 8'h0C, 32'h0);
            check(wb_dat_o, 32'h0);
            check({12'h0, clkOutEn, clkOut}, 32'h0);
        end
    endtask
    task tFan(input v);
        begin
            wb(1'b1, 8'h00, {31'h0, v});
            repeat (24) @(posedge clk);
            check({22'h0, clkOutEn}, 32'h3FF);
            for (i = 0; i < 14; i = i + 1) begin
                lvl = {lvl[1:0], v ? clockInputOne : clockInputZero};
                if (i > 1) check({31'h0, clkOut[0]}, {31'h0, lvl[2]});
                @(posedge clk);
            end
        end
    endtask
    task tHalf;
        begin
            run <= 1'b0;
            wb(1'b1, 8'h00, 32'h1A);
            repeat (4) @(posedge clk);
            wb(1'b1, 8'h00, 32'h18);
            repeat (20) @(posedge clk);
            check({12'h0, clkOutEn, clkOut}, 32'hFFC00);
            wb(1'b0, 8'h04, 32'h0);
            check(wb_dat_o, 32'h4);
            wb(1'b0, 8'h08, 32'h0);
            edges = wb_dat_o;
            run <= 1'b1;
            i = 0;
            while (clkOut[0] !== 1'b1 && i < 40) begin
                i = i + 1;
                @(posedge clk);
            end
            check({22'h0, clkOut}, 32'h3FF);
            repeat (4) @(posedge clk);
            check({22'h0, clkOut}, 32'h00F);
            repeat (4) @(posedge clk);
            check({22'h0, clkOut}, 32'h3FF);
            run <= 1'b0;
            wb(1'b0, 8'h08, 32'h0);
            check(wb_dat_o, edges + 32'h3);
        end
    endtask
    task test_done;
        begin
            $display("errors %0d of %0d", num_errors, n_compared);
            if (num_errors == 0 && n_compared > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    initial begin
        #20000;
        num_errors = num_errors + 1;
        test_done;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        tReset;
        tFan(1'b0);
        tFan(1'b1);
        tHalf;
        test_done;
    end
endmodule // test_cfd_top
